//--- inc/ppk_pkg.sv
// ----------------------------------------------------------------------
// shared constants of the pixel unpacker
// ----------------------------------------------------------------------
package ppk_pkg;
  // lane count and lane word width
  localparam int PPK_LANES = 16;
  localparam int PPK_WORD_W = 32;
  // colour depth at the outputs
  localparam int PPK_COLOR_W = 10;
  // skew buffer per lane, deep enough for one display line of 240 words
  localparam int PPK_DEPTH = 256;
  localparam int PPK_PTR_W = 9;
  localparam logic [PPK_PTR_W-1:0] PPK_FULL = 9'h100;
  localparam logic [PPK_PTR_W-1:0] PPK_PTR_RST = 9'h000;
  // byte field positions in a lane word
  localparam int PPK_RED_LSB = 0;
  localparam int PPK_GRN_LSB = 8;
  localparam int PPK_BLU_LSB = 16;
  localparam int PPK_RED_LOW_LSB = 30;
  localparam int PPK_GRN_LOW_LSB = 28;
  localparam int PPK_BLU_LOW_LSB = 26;
  // reset values
  localparam logic PPK_MODE_RST = 1'b1;
  localparam logic [PPK_COLOR_W-1:0] PPK_COLOR_RST = 10'h000;
  // depth selection encodings
  typedef enum logic {PPK_MODE_8BIT, PPK_MODE_10BIT} ppk_mode_t;
endpackage

//--- logic/ppk_unpacker.sv
`timescale 1ns/10ps
// Notes on behaviour
// - ten-bit uses four bytes, eight-bit uses three
// - bytes zero to two carry red, green, blue
// - byte three carries two low bits each
// - larger code value gives brighter output level
// - lanes of a sub-block deskewed up to five
// - sub-blocks aligned across one data-enable period
// - depth select high means ten-bit, low eight-bit
module ppk_unpacker
  import ppk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_bit_sel,
  input wire logic [PPK_LANES-1:0] i_lane_de,
  input wire logic [PPK_LANES-1:0][PPK_WORD_W-1:0] i_lane_word,
  output logic o_pix_valid,
  output logic o_mode_10bit,
  output logic o_align_err,
  output logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] o_red,
  output logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] o_green,
  output logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] o_blue
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic sel_meta; // first stage, read only by sel_sync
  logic sel_sync;
  logic [PPK_LANES-1:0] de_meta; // first stage of data enables
  logic [PPK_LANES-1:0] de_sync;
  logic [PPK_LANES-1:0][PPK_WORD_W-1:0] word_meta; // first stage of words
  logic [PPK_LANES-1:0][PPK_WORD_W-1:0] word_sync;

  // two flops on every input pin except clock and reset before use
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sel_meta <= PPK_MODE_RST;
      sel_sync <= PPK_MODE_RST;
      de_meta <= '0;
      de_sync <= '0;
      word_meta <= '0;
      word_sync <= '0;
    end
    else
    begin
      sel_meta <= i_bit_sel;
      sel_sync <= sel_meta;
      de_meta <= i_lane_de;
      de_sync <= de_meta;
      word_meta <= i_lane_word;
      word_sync <= word_meta;
    end
  end

  // ----------------------------------------------------------------------
  // depth selection
  // ----------------------------------------------------------------------
  ppk_mode_t mode; // current packing depth

  // high or open pin selects ten-bit packing, low selects eight-bit
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mode <= PPK_MODE_10BIT;
    else if (sel_sync)
      mode <= PPK_MODE_10BIT;
    else
      mode <= PPK_MODE_8BIT;
  end

  // ----------------------------------------------------------------------
  // per lane skew buffers
  // ----------------------------------------------------------------------
  logic [PPK_WORD_W-1:0] mem [PPK_LANES][PPK_DEPTH]; // stored lane words
  logic [PPK_PTR_W-1:0] wr_ptr [PPK_LANES]; // write index with wrap bit
  logic [PPK_PTR_W-1:0] rd_ptr; // shared read index, lanes leave together
  logic [PPK_PTR_W-1:0] fill [PPK_LANES]; // words held per lane
  logic [PPK_LANES-1:0] has_data; // lane holds at least one word
  logic [PPK_LANES-1:0] ovf; // write attempted into a full lane with no read in the same cycle
  logic [PPK_LANES-1:0][PPK_WORD_W-1:0] rd_word; // words at the read index
  logic rd_en; // every lane has a word, release one pixel set

  // occupancy and head word of each lane
  always_comb
  begin
    for (int l = 0; l < PPK_LANES; l++)
    begin
      fill[l] = wr_ptr[l] - rd_ptr;
      has_data[l] = (fill[l] != PPK_PTR_RST);
      ovf[l] = de_sync[l] && (fill[l] == PPK_FULL) && !rd_en;
      rd_word[l] = mem[l][rd_ptr[PPK_PTR_W-2:0]];
    end
  end

  // a pixel set leaves only when the latest lane has caught up
  assign rd_en = &has_data;

  generate
    for (genvar g = 0; g < PPK_LANES; g++)
    begin : g_lane
      // each lane writes its own words as its own enable arrives
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          wr_ptr[g] <= PPK_PTR_RST;
        else if (de_sync[g] && !ovf[g])
          wr_ptr[g] <= wr_ptr[g] + 9'h001;
      end

      // storage has no reset, it is only read behind a valid pointer
      always_ff @(posedge i_clk)
      begin
        if (de_sync[g] && !ovf[g])
          mem[g][wr_ptr[g][PPK_PTR_W-2:0]] <= word_sync[g];
      end
    end
  endgenerate

  // read index advances once per released pixel set
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rd_ptr <= PPK_PTR_RST;
    else if (rd_en)
      rd_ptr <= rd_ptr + 9'h001;
  end

  // skew beyond 256 words is lost data; flag holds until reset
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_align_err <= 1'b0;
    else if (|ovf)
      o_align_err <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // unpacking into ten-bit levels
  // ----------------------------------------------------------------------
  // high bytes hold the upper bits; low bits come from byte three in
  // ten-bit mode and are filled from the top bits in eight-bit mode, so
  // full scale stays full scale and larger codes stay brighter
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pix_valid <= 1'b0;
      o_mode_10bit <= PPK_MODE_RST;
      for (int l = 0; l < PPK_LANES; l++)
      begin
        o_red[l] <= PPK_COLOR_RST;
        o_green[l] <= PPK_COLOR_RST;
        o_blue[l] <= PPK_COLOR_RST;
      end
    end
    else
    begin
      o_pix_valid <= rd_en;
      o_mode_10bit <= (mode == PPK_MODE_10BIT);
      if (rd_en)
      begin
        for (int l = 0; l < PPK_LANES; l++)
        begin
          // upper eight bits of each colour
          o_red[l][9:2] <= rd_word[l][PPK_RED_LSB +: 8];
          o_green[l][9:2] <= rd_word[l][PPK_GRN_LSB +: 8];
          o_blue[l][9:2] <= rd_word[l][PPK_BLU_LSB +: 8];
          if (mode == PPK_MODE_10BIT)
          begin
            // fourth byte, bits 25:24 ignored
            o_red[l][1:0] <= rd_word[l][PPK_RED_LOW_LSB +: 2];
            o_green[l][1:0] <= rd_word[l][PPK_GRN_LOW_LSB +: 2];
            o_blue[l][1:0] <= rd_word[l][PPK_BLU_LOW_LSB +: 2];
          end
          else
          begin
            // three-byte word, top byte unused
            o_red[l][1:0] <= rd_word[l][PPK_RED_LSB+6 +: 2];
            o_green[l][1:0] <= rd_word[l][PPK_GRN_LSB+6 +: 2];
            o_blue[l][1:0] <= rd_word[l][PPK_BLU_LSB+6 +: 2];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_byte_layout;
    @(posedge i_clk) disable iff (!i_rstn)
    rd_en |=> (o_red[0][9:2] == $past(rd_word[0][7:0]))
      && (o_green[0][9:2] == $past(rd_word[0][15:8]))
      && (o_blue[0][9:2] == $past(rd_word[0][23:16]));
  endproperty
  a_byte_layout: assert property (p_byte_layout)
    else $error("colour bytes misplaced");

  property p_low_bits_10;
    @(posedge i_clk) disable iff (!i_rstn)
    (rd_en && mode == PPK_MODE_10BIT) |=> (o_red[1][1:0] == $past(rd_word[1][31:30]))
      && (o_green[1][1:0] == $past(rd_word[1][29:28]))
      && (o_blue[1][1:0] == $past(rd_word[1][27:26]));
  endproperty
  a_low_bits_10: assert property (p_low_bits_10)
    else $error("low colour bits wrong in four byte mode");

  property p_three_byte;
    @(posedge i_clk) disable iff (!i_rstn)
    (rd_en && mode == PPK_MODE_8BIT) |=> !o_mode_10bit
      && (o_red[0][1:0] == $past(rd_word[0][7:6]))
      && (o_blue[0][1:0] == $past(rd_word[0][23:22]));
  endproperty
  a_three_byte: assert property (p_three_byte)
    else $error("three byte word used its fourth byte");

  property p_monotonic;
    @(posedge i_clk) disable iff (!i_rstn)
    (rd_en && rd_word[0][7:0] > rd_word[1][7:0]) |=> (o_red[0] > o_red[1]);
  endproperty
  a_monotonic: assert property (p_monotonic)
    else $error("larger code did not give larger level");

  property p_mode_select;
    @(posedge i_clk) disable iff (!i_rstn)
    ##3 ((mode == PPK_MODE_10BIT) == $past(i_bit_sel, 3));
  endproperty
  a_mode_select: assert property (p_mode_select)
    else $error("depth mode does not follow select pin");

  property p_hold_skew;
    @(posedge i_clk) disable iff (!i_rstn)
    (|has_data && !(&has_data)) |=> !o_pix_valid;
  endproperty
  a_hold_skew: assert property (p_hold_skew)
    else $error("pixel released before all lanes arrived");

  property p_release;
    @(posedge i_clk) disable iff (!i_rstn)
    (&has_data) |=> o_pix_valid ##0 (rd_ptr == $past(rd_ptr) + 9'h001);
  endproperty
  a_release: assert property (p_release)
    else $error("aligned pixel set not released");

  property p_align_err;
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(o_align_err) |-> $past(fill[0] == PPK_FULL || |ovf);
  endproperty
  a_align_err: assert property (p_align_err)
    else $error("alignment error without overflow");

  // a word offered to a full lane with no read pending is refused
  property p_full_refuse;
    @(posedge i_clk) disable iff (!i_rstn)
    (de_sync[0] && fill[0] == PPK_FULL && !rd_en) |=> o_align_err
      && (wr_ptr[0] == $past(wr_ptr[0]));
  endproperty
  a_full_refuse: assert property (p_full_refuse)
    else $error("word written into a full lane");

  c_mode8: cover property (@(posedge i_clk) disable iff (!i_rstn)
    rd_en && mode == PPK_MODE_8BIT);
  c_mode10: cover property (@(posedge i_clk) disable iff (!i_rstn)
    rd_en && mode == PPK_MODE_10BIT);
  c_skewed: cover property (@(posedge i_clk) disable iff (!i_rstn)
    (|has_data && !(&has_data)) ##1 rd_en);
  c_overflow: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_align_err));

endmodule

//--- dv/ppk_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// host video source: packs pixels and feeds the lanes
// ----------------------------------------------------------------------
module ppk_host_model
  import ppk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_pack_10bit,
  input wire logic [PPK_LANES-1:0] i_stall,
  output logic [PPK_LANES-1:0] o_lane_de,
  output logic [PPK_LANES-1:0][PPK_WORD_W-1:0] o_lane_word
);
  // words waiting per lane
  logic [PPK_WORD_W-1:0] lane_q[PPK_LANES][$];

  // power sequencing: every interval is a count of milliseconds, and one
  // millisecond is shortened to one clock so a run stays short
  localparam int MS_CYC = 1;
  localparam int T2_MS = 200; // upper bound of the supply to lines delay
  localparam int T3_MS = 800; // lines live before they are dropped
  localparam int T4_MS = 100; // lines quiet before supply drops
  localparam int T5_MS = 1000; // supply off time before it returns
  localparam int T6_MS = 2; // lines follow supply, never past T2
  localparam int T7_MS = 0; // ordering margin, never negative
  logic panel_supply = 1'b0; // panel supply switched on
  logic lines_live = 1'b0; // interface lines may carry traffic

  // lines held low and inactive until supply and lines go live; idle words toggle after that
  initial
  begin
    o_lane_de = '0;
    o_lane_word = '0;
  end

  // pack one pixel for one lane as the depth pin asks
  task automatic push(input int lane, input logic [9:0] r, input logic [9:0] g,
                      input logic [9:0] b);
    logic [31:0] w;
    if (i_pack_10bit == 1'b1)
      w = {r[1:0], g[1:0], b[1:0], 2'h3, b[9:2], g[9:2], r[9:2]};
    else
      w = {8'hA5, b[7:0], g[7:0], r[7:0]};
    lane_q[lane].push_back(w);
  endtask

  // supply first, then the lines after a delay no longer than T2
  task automatic power_on();
    @(posedge i_clk);
    panel_supply = 1'b1;
    repeat ((T6_MS < T2_MS ? T6_MS : T2_MS) * MS_CYC) @(posedge i_clk);
    lines_live = 1'b1;
  endtask

  // lines dropped low, supply off for the full off time, then back on
  task automatic power_cycle();
    repeat (T3_MS * MS_CYC) @(posedge i_clk);
    lines_live = 1'b0;
    repeat ((T4_MS + T7_MS) * MS_CYC) @(posedge i_clk);
    panel_supply = 1'b0;
    repeat (T5_MS * MS_CYC) @(posedge i_clk);
    power_on();
  endtask

  // lanes with queued words leave together unless stalled, so skew comes from stalls and uneven queues
  always @(negedge i_clk)
  begin
    for (int l = 0; l < PPK_LANES; l++)
    begin
      if (!(panel_supply && lines_live))
      begin
        // supply off or lines not yet enabled: pulled low, nothing valid
        o_lane_de[l] <= 1'b0;
        o_lane_word[l] <= '0;
      end
      else if (lane_q[l].size() > 0 && i_stall[l] == 1'b0)
      begin
        o_lane_de[l] <= 1'b1;
        o_lane_word[l] <= lane_q[l].pop_front();
      end
      else
      begin
        // idle word toggles, never left floating
        o_lane_de[l] <= 1'b0;
        o_lane_word[l] <= ~o_lane_word[l];
      end
    end
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import ppk_pkg::*;
;
  // ----------------------------------------------------------------------
  // wiring and bookkeeping
  // ----------------------------------------------------------------------
  logic clk;
  logic rstn;
  logic bit_sel;
  logic [PPK_LANES-1:0] stall;
  logic [PPK_LANES-1:0] lane_de;
  logic [PPK_LANES-1:0][PPK_WORD_W-1:0] lane_word;
  logic pix_valid;
  logic mode_10bit;
  logic align_err;
  logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] red, green, blue;
  logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] exp_r[$], exp_g[$], exp_b[$];
  int n_fail = 0;
  int samples_checked = 0;

  ppk_unpacker ppk_unpacker_inst (.i_clk(clk), .i_rstn(rstn), .i_bit_sel(bit_sel),
    .i_lane_de(lane_de), .i_lane_word(lane_word), .o_pix_valid(pix_valid),
    .o_mode_10bit(mode_10bit), .o_align_err(align_err), .o_red(red), .o_green(green),
    .o_blue(blue));
  ppk_host_model ppk_host_model_inst (.i_clk(clk), .i_pack_10bit(bit_sel),
    .i_stall(stall), .o_lane_de(lane_de), .o_lane_word(lane_word));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // queue one pixel set on all lanes and its expected levels
  task automatic send_set(input int n);
    logic [PPK_LANES-1:0][PPK_COLOR_W-1:0] r, g, b;
    for (int l = 0; l < PPK_LANES; l++)
    begin
      r[l] = 10'(n * 37 + l * 61);
      g[l] = 10'(n * 113 + l * 29 + 7);
      b[l] = 10'(n * 5 + l * 211 + 500);
      ppk_host_model_inst.push(l, r[l], g[l], b[l]);
      if (bit_sel == 1'b0)
      begin
        // eight-bit levels widen by replicating their top bits
        r[l] = {r[l][7:0], r[l][7:6]};
        g[l] = {g[l][7:0], g[l][7:6]};
        b[l] = {b[l][7:0], b[l][7:6]};
      end
    end
    exp_r.push_back(r);
    exp_g.push_back(g);
    exp_b.push_back(b);
  endtask

  // bounded wait until every expected set came out
  task automatic wait_done();
    int k;
    k = 0;
    while (exp_r.size() != 0 && k < 600)
    begin
      @(negedge clk);
      k++;
    end
    check("pending_sets", 160'(exp_r.size()), 160'h0);
  endtask

  // compare every released set where the outputs are settled
  always @(negedge clk)
  begin
    if (pix_valid === 1'b1)
    begin
      if (exp_r.size() == 0)
        check("extra_set", 160'h1, 160'h0);
      else
      begin
        check("red", red, exp_r.pop_front());
        check("green", green, exp_g.pop_front());
        check("blue", blue, exp_b.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_modes();
    for (int n = 0; n < 4; n++)
      send_set(n);
    wait_done();
    bit_sel = 1'b0;
    repeat (6) @(negedge clk);
    check("mode_8bit", 160'(mode_10bit), 160'h0);
    for (int n = 4; n < 8; n++)
      send_set(n);
    wait_done();
    bit_sel = 1'b1;
    repeat (6) @(negedge clk);
    check("mode_10bit", 160'(mode_10bit), 160'h1);
  endtask

  // lane 5 three words late must still pair by word order
  task automatic t_skew();
    @(posedge clk);
    stall = 16'h0020;
    for (int n = 8; n < 12; n++)
      send_set(n);
    repeat (3) @(posedge clk);
    stall = 16'h0000;
    @(negedge clk);
    wait_done();
  endtask

  // supply dropped and restored: no release while off, traffic resumes after
  task automatic t_power();
    ppk_host_model_inst.power_cycle();
    check("align_err_power", 160'(align_err), 160'h0);
    for (int n = 12; n < 14; n++)
      send_set(n);
    wait_done();
  endtask

  // lane 0 alone fills its buffer; the word past full is refused
  task automatic t_overflow();
    for (int k = 0; k < 256; k++)
      ppk_host_model_inst.push(0, 10'h155, 10'h2AA, 10'h3FF);
    repeat (270) @(negedge clk);
    check("align_err_full", 160'(align_err), 160'h0);
    ppk_host_model_inst.push(0, 10'h000, 10'h000, 10'h000);
    repeat (10) @(negedge clk);
    check("align_err_over", 160'(align_err), 160'h1);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("align_err_reset", 160'(align_err), 160'h0);
  endtask

  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial
  begin
    rstn = 1'b0;
    bit_sel = 1'b1;
    stall = '0;
    fork
      ppk_host_model_inst.power_on();
    join_none
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("reset_state", 160'({pix_valid, align_err, mode_10bit}), 160'h1);
    t_modes();
    t_skew();
    t_power();
    t_overflow();
    finish_test();
  end
endmodule
